// ### acq_pkg.sv
// Shared constants, encodings and state carrier of the acquisition sequencer.
package acq_pkg;

	// ****************************************************************
	// Sensor timing
	// ****************************************************************
	localparam logic [11:0] ROW_CYCLES    = 12'hA40;
	localparam logic [11:0] ROI_MAX_ROWS  = 12'h438;
	localparam logic [11:0] ROI_MIN_ROWS  = 12'h001;

	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [7:0] OFS_CTRL        = 8'h00;
	localparam logic [7:0] OFS_CFG         = 8'h04;
	localparam logic [7:0] OFS_FRAME_COUNT = 8'h08;
	localparam logic [7:0] OFS_EXPOSURE    = 8'h0C;
	localparam logic [7:0] OFS_ROI         = 8'h10;
	localparam logic [7:0] OFS_PERIOD      = 8'h14;
	localparam logic [7:0] OFS_STATUS      = 8'h18;
	localparam logic [7:0] OFS_SENT        = 8'h1C;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int CTRL_START_BIT   = 0;
	localparam int CTRL_ABORT_BIT   = 1;
	localparam int CTRL_SWTRIG_BIT  = 2;
	localparam int CFG_MODE_LSB     = 0;
	localparam int CFG_GLOBAL_BIT   = 2;
	localparam int CFG_INTERNAL_BIT = 3;
	localparam int ST_BUSY_BIT      = 0;
	localparam int ST_READY_BIT     = 1;
	localparam int ST_ACTIVE_BIT    = 2;
	localparam int ST_OVERFLOW_BIT  = 3;
	localparam int ST_LONG_BIT      = 4;
	localparam int ST_EMPTY_BIT     = 5;
	localparam int ST_FULL_BIT      = 6;
	localparam int ST_COUNT_LSB     = 8;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [31:0] FRAME_COUNT_RST = 32'h0000_0001;
	localparam logic [31:0] EXPOSURE_RST    = 32'h0000_0A40;
	localparam logic [31:0] PERIOD_RST      = 32'h0000_0000;

	// ****************************************************************
	// Encodings
	// ****************************************************************
	typedef enum logic [1:0] {
		MODE_SINGLE     = 2'b00,
		MODE_SERIES     = 2'b01,
		MODE_ACCUMULATE = 2'b10,
		MODE_CONTINUOUS = 2'b11
	} acq_mode_e;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_ARMED   = 2'b01,
		ST_EXPOSE  = 2'b10,
		ST_READOUT = 2'b11
	} seq_state_e;

	// ****************************************************************
	// Sequencer state
	// ****************************************************************
	typedef struct packed {
		seq_state_e  state;
		acq_mode_e   mode;
		logic        global_shutter;
		logic        internal_trig;
		logic [31:0] frame_count;
		logic [31:0] exposure;
		logic [11:0] region_of_interest;
		logic [31:0] period;
		logic [31:0] run_period;
		logic [31:0] cur_exp;
		logic [31:0] exp_elapsed;
		logic [11:0] row_cnt;
		logic [12:0] rows_left;
		logic        long_exp;
		logic [31:0] frames_taken;
		logic [31:0] frames_sent;
		logic [31:0] rate_cnt;
		logic        trig_prev;
		logic        overflow;
		logic [31:0] prdata;
		logic        pslverr;
	} seq_s;

endpackage

// ### frame_store.sv
// Frame unit store: first-in first-out memory of captured frame tags.
`timescale 1ns/1ps
module frame_store #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input  wire logic                       clock_i,
	input  wire logic                       sys_rst_i,
	input  wire logic                       flush_i,
	input  wire logic                       push_valid_i,
	output logic                            push_ready_o,
	input  wire logic [WIDTH-1:0]           push_data_i,
	output logic                            pop_valid_o,
	input  wire logic                       pop_ready_i,
	output logic [WIDTH-1:0]                pop_data_o,
	output logic [$clog2(DEPTH+1)-1:0]      count_o
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH+1);
	localparam logic [PW-1:0] LAST = PW'(DEPTH-1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               wr;
		logic [PW-1:0]               rd;
		logic [CW-1:0]               count;
	} store_s;

	store_s q;
	store_s d;
	logic   do_push;
	logic   do_pop;

	assign push_ready_o = (q.count != FULL);
	assign pop_valid_o  = (q.count != '0);
	assign pop_data_o   = q.mem[q.rd];
	assign count_o      = q.count;
	assign do_push      = push_valid_i & push_ready_o;
	assign do_pop       = pop_valid_o & pop_ready_i;

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		d = q;
		if (do_push) begin
			d.mem[q.wr] = push_data_i;
			d.wr = (q.wr == LAST) ? '0 : q.wr + 1'b1;
		end
		if (do_pop) begin
			d.rd = (q.rd == LAST) ? '0 : q.rd + 1'b1;
		end
		if (do_push && !do_pop) begin
			d.count = q.count + 1'b1;
		end else if (do_pop && !do_push) begin
			d.count = q.count - 1'b1;
		end
		if (flush_i) begin
			d.wr = '0;
			d.rd = '0;
			d.count = '0;
		end
	end

	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

endmodule

// ### camera_acquisition_sequencer.sv
// Acquisition sequencer: triggers, exposure, readout, frame store and APB.
//
// Function
// - Exposure rounds up to whole row periods in every trigger mode.
// - One row period is a fixed count of readout clock cycles.
// - Frame length in rows follows region of interest height, full is 1080.
// - Exposure below frame time is short, above frame time is long.
// - On-the-fly exposure changes stay within the range of the running class.
// - Frame unit is one frame rolling, reference plus image frame global.
// - Only triggers arriving while ready produce a frame.
// - One-frame mode takes the first valid trigger, ignores the rest.
// - Counted series takes valid triggers until frame count is reached.
// - Series may fill memory; host limits count, capture stalls when full.
// - Accumulate mode sends each frame unit unmodified.
// - Continuous mode takes valid triggers without limit until aborted.
// - Continuous mode aborts the acquisition when memory becomes full.
// - Stored frames are read from memory and sent to the host link.
// - A new exposure applies from the next frame unit, rewrites unlimited.
// - Internal trigger runs at maximum rate or programmed lower rate.
// - Ready is high exactly when a rising trigger edge would be taken in external trigger mode.
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ps
module camera_acquisition_sequencer #(
	parameter int STORE_DEPTH = 8,
	parameter int TAG_WIDTH   = 16
) (
	input  wire logic                  clock_i,
	input  wire logic                  sys_rst_i,
	input  wire logic                  psel_i,
	input  wire logic                  penable_i,
	input  wire logic                  pwrite_i,
	input  wire logic [7:0]            paddr_i,
	input  wire logic [31:0]           pwdata_i,
	output logic [31:0]                prdata_o,
	output logic                       pready_o,
	output logic                       pslverr_o,
	input  wire logic                  trigger_i,
	output logic                       ready_o,
	output logic                       expose_o,
	output logic                       readout_o,
	output logic                       active_o,
	output logic                       tx_valid_o,
	input  wire logic                  tx_ready_i,
	output logic [TAG_WIDTH-1:0]       tx_tag_o
);

	localparam int CW = $clog2(STORE_DEPTH+1);

	acq_pkg::seq_s       q;
	acq_pkg::seq_s       d;
	logic                push;
	logic                flush;
	logic                store_ready;
	logic [CW-1:0]       store_count;
	logic                tx_fire;
	logic [31:0]         frame_cyc;
	logic [31:0]         new_exp;
	logic [31:0]         status;
	logic [32:0]         elapsed_next;
	logic [12:0]         unit_rows;
	logic                wr_en;
	logic                setup;
	logic                start_req;
	logic                abort_req;
	logic                sw_trig;
	logic                trig_rise;
	logic                rate_due;
	logic                limit_hit;
	logic                ready;
	logic                trig_take;
	logic                mapped;
	logic [31:0]         rd_mux;

	// ****************************************************************
	// Frame store
	// ****************************************************************
	frame_store #(
		.WIDTH (TAG_WIDTH),
		.DEPTH (STORE_DEPTH)
	) u_store (
		.clock_i      (clock_i),
		.sys_rst_i    (sys_rst_i),
		.flush_i      (flush),
		.push_valid_i (push),
		.push_ready_o (store_ready),
		.push_data_i  (q.frames_taken[TAG_WIDTH-1:0]),
		.pop_valid_o  (tx_valid_o),
		.pop_ready_i  (tx_ready_i),
		.pop_data_o   (tx_tag_o),
		.count_o      (store_count)
	);

	assign tx_fire = tx_valid_o & tx_ready_i;

	// ****************************************************************
	// Bus decode
	// ****************************************************************
	assign setup     = psel_i & ~penable_i;
	assign wr_en     = psel_i & penable_i & pwrite_i;
	assign pready_o  = psel_i & penable_i;
	assign prdata_o  = q.prdata;
	assign pslverr_o = q.pslverr;
	assign start_req = wr_en && (paddr_i == acq_pkg::OFS_CTRL)
		&& pwdata_i[acq_pkg::CTRL_START_BIT];
	assign abort_req = wr_en && (paddr_i == acq_pkg::OFS_CTRL)
		&& pwdata_i[acq_pkg::CTRL_ABORT_BIT];
	assign sw_trig   = wr_en && (paddr_i == acq_pkg::OFS_CTRL)
		&& pwdata_i[acq_pkg::CTRL_SWTRIG_BIT];
	assign mapped    = (paddr_i[1:0] == 2'b00) && (paddr_i[7:5] == 3'b000);

	// ****************************************************************
	// Timing terms
	// ****************************************************************
	// The frame time is recomputed from the height each cycle so that a
	// new height is seen by the classification without an extra register.
	assign frame_cyc = 32'(q.region_of_interest) * 32'(acq_pkg::ROW_CYCLES);
	assign elapsed_next = {1'b0, q.exp_elapsed}
		+ 33'(acq_pkg::ROW_CYCLES);
	assign unit_rows = q.global_shutter ? {q.region_of_interest, 1'b0}
		: {1'b0, q.region_of_interest};

	// ****************************************************************
	// Trigger qualification
	// ****************************************************************
	assign trig_rise = trigger_i & ~q.trig_prev;
	assign rate_due  = (q.rate_cnt >= q.run_period);
	always_comb begin
		case (q.mode)
			acq_pkg::MODE_SINGLE: begin
				limit_hit = (q.frames_taken != 32'h0000_0000);
			end
			acq_pkg::MODE_CONTINUOUS: begin
				limit_hit = 1'b0;
			end
			default: begin
				limit_hit = (q.frames_taken >= q.frame_count);
			end
		endcase
	end
	// Capture also stalls on a full store, so a series that outruns the
	// link simply waits rather than overwriting stored units.
	assign ready = (q.state == acq_pkg::ST_ARMED) && store_ready
		&& !limit_hit && !abort_req;
	assign trig_take = ready && (q.internal_trig ? rate_due
		: (trig_rise | sw_trig));

	assign ready_o   = ready;
	assign expose_o  = (q.state == acq_pkg::ST_EXPOSE);
	assign readout_o = (q.state == acq_pkg::ST_READOUT);
	assign active_o  = (q.state != acq_pkg::ST_IDLE);

	// ****************************************************************
	// Exposure clamp
	// ****************************************************************
	always_comb begin
		new_exp = pwdata_i;
		if (q.state != acq_pkg::ST_IDLE) begin
			if (q.long_exp && (pwdata_i <= frame_cyc)) begin
				new_exp = frame_cyc + 32'h0000_0001;
			end else if (!q.long_exp && (pwdata_i >= frame_cyc)) begin
				new_exp = frame_cyc - 32'h0000_0001;
			end
		end
	end

	// ****************************************************************
	// Read data
	// ****************************************************************
	always_comb begin
		status = 32'h0000_0000;
		status[acq_pkg::ST_BUSY_BIT] = (q.state != acq_pkg::ST_IDLE)
			|| tx_valid_o;
		status[acq_pkg::ST_READY_BIT] = ready;
		status[acq_pkg::ST_ACTIVE_BIT] = (q.state != acq_pkg::ST_IDLE);
		status[acq_pkg::ST_OVERFLOW_BIT] = q.overflow;
		status[acq_pkg::ST_LONG_BIT] = !(q.exposure < frame_cyc);
		status[acq_pkg::ST_EMPTY_BIT] = !tx_valid_o;
		status[acq_pkg::ST_FULL_BIT] = !store_ready;
		status[acq_pkg::ST_COUNT_LSB +: 8] = 8'(store_count);
		case (paddr_i)
			acq_pkg::OFS_CFG: begin
				rd_mux = {28'h000_0000, q.internal_trig,
					q.global_shutter, q.mode};
			end
			acq_pkg::OFS_FRAME_COUNT: begin
				rd_mux = q.frame_count;
			end
			acq_pkg::OFS_EXPOSURE: begin
				rd_mux = q.exposure;
			end
			acq_pkg::OFS_ROI: begin
				rd_mux = {20'h0_0000, q.region_of_interest};
			end
			acq_pkg::OFS_PERIOD: begin
				rd_mux = q.period;
			end
			acq_pkg::OFS_STATUS: begin
				rd_mux = status;
			end
			acq_pkg::OFS_SENT: begin
				rd_mux = q.frames_sent;
			end
			default: begin
				rd_mux = 32'h0000_0000;
			end
		endcase
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		d = q;
		push = 1'b0;
		flush = 1'b0;
		d.trig_prev = trigger_i;
		if (setup) begin
			d.prdata = mapped ? rd_mux : 32'h0000_0000;
			d.pslverr = !mapped;
		end
		if (tx_fire) begin
			d.frames_sent = q.frames_sent + 32'h0000_0001;
		end
		if (q.rate_cnt != 32'hFFFF_FFFF) begin
			d.rate_cnt = q.rate_cnt + 32'h0000_0001;
		end

		// Configuration is frozen while running except the exposure.
		if (wr_en && (q.state == acq_pkg::ST_IDLE)) begin
			case (paddr_i)
				acq_pkg::OFS_CFG: begin
					d.mode = acq_pkg::acq_mode_e'(
						pwdata_i[acq_pkg::CFG_MODE_LSB +: 2]);
					d.global_shutter = pwdata_i[acq_pkg::CFG_GLOBAL_BIT];
					d.internal_trig = pwdata_i[acq_pkg::CFG_INTERNAL_BIT];
				end
				acq_pkg::OFS_FRAME_COUNT: begin
					d.frame_count = pwdata_i;
				end
				acq_pkg::OFS_ROI: begin
					if (pwdata_i[11:0] == 12'h000
						|| pwdata_i[31:12] != 20'h0_0000) begin
						d.region_of_interest = (pwdata_i[11:0] == 12'h000
							&& pwdata_i[31:12] == 20'h0_0000)
							? acq_pkg::ROI_MIN_ROWS
							: acq_pkg::ROI_MAX_ROWS;
					end else if (pwdata_i[11:0] > acq_pkg::ROI_MAX_ROWS) begin
						d.region_of_interest = acq_pkg::ROI_MAX_ROWS;
					end else begin
						d.region_of_interest = pwdata_i[11:0];
					end
				end
				acq_pkg::OFS_PERIOD: begin
					d.period = pwdata_i;
				end
				default: begin
				end
			endcase
		end
		if (wr_en && (paddr_i == acq_pkg::OFS_EXPOSURE)) begin
			d.exposure = new_exp;
		end

		case (q.state)
			acq_pkg::ST_IDLE: begin
				if (start_req && !abort_req) begin
					d.state = acq_pkg::ST_ARMED;
					d.frames_taken = 32'h0000_0000;
					d.overflow = 1'b0;
					d.run_period = q.period;
					d.rate_cnt = 32'hFFFF_FFFF;
					d.long_exp = !(q.exposure < frame_cyc);
				end
			end
			acq_pkg::ST_ARMED: begin
				if (trig_take) begin
					d.state = acq_pkg::ST_EXPOSE;
					d.cur_exp = q.exposure;
					d.exp_elapsed = 32'h0000_0000;
					d.row_cnt = 12'h000;
					d.rate_cnt = 32'h0000_0000;
				end else if (limit_hit) begin
					d.state = acq_pkg::ST_IDLE;
				end else if (q.mode == acq_pkg::MODE_CONTINUOUS
					&& !store_ready) begin
					d.state = acq_pkg::ST_IDLE;
					d.overflow = 1'b1;
					flush = 1'b1;
				end
			end
			acq_pkg::ST_EXPOSE: begin
				if (q.row_cnt == acq_pkg::ROW_CYCLES - 12'h001) begin
					d.row_cnt = 12'h000;
					if (elapsed_next >= {1'b0, q.cur_exp}) begin
						d.state = acq_pkg::ST_READOUT;
						d.rows_left = unit_rows;
					end else begin
						d.exp_elapsed = elapsed_next[31:0];
					end
				end else begin
					d.row_cnt = q.row_cnt + 12'h001;
				end
			end
			acq_pkg::ST_READOUT: begin
				if (q.row_cnt == acq_pkg::ROW_CYCLES - 12'h001) begin
					d.row_cnt = 12'h000;
					d.rows_left = q.rows_left - 13'h0001;
					if (q.rows_left == 13'h0001) begin
						push = 1'b1;
						d.frames_taken = q.frames_taken + 32'h0000_0001;
						d.state = acq_pkg::ST_ARMED;
					end
				end else begin
					d.row_cnt = q.row_cnt + 12'h001;
				end
			end
			default: begin
				d.state = acq_pkg::ST_IDLE;
			end
		endcase

		// Abort also discards units not yet sent, so the next acquisition
		// never delivers stale frames from the one that was stopped.
		if (abort_req) begin
			d.state = acq_pkg::ST_IDLE;
			d.row_cnt = 12'h000;
			push = 1'b0;
			flush = 1'b1;
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			q <= '0;
			q.frame_count <= acq_pkg::FRAME_COUNT_RST;
			q.exposure <= acq_pkg::EXPOSURE_RST;
			q.region_of_interest <= acq_pkg::ROI_MAX_ROWS;
			q.period <= acq_pkg::PERIOD_RST;
			q.run_period <= acq_pkg::PERIOD_RST;
		end else begin
			q <= d;
		end
	end

endmodule

// ### camera_acquisition_sequencer_props.sv
// Port-level assertion checker for the acquisition sequencer.
`timescale 1ns/1ps
module camera_acquisition_sequencer_props #(
	parameter int TAG_WIDTH = 16
) (
	input  wire logic                 clock_i,
	input  wire logic                 sys_rst_i,
	input  wire logic                 psel_i,
	input  wire logic                 penable_i,
	input  wire logic                 pwrite_i,
	input  wire logic [7:0]           paddr_i,
	input  wire logic [31:0]          pwdata_i,
	input  wire logic                 ready_o,
	input  wire logic                 expose_o,
	input  wire logic                 readout_o,
	input  wire logic                 active_o,
	input  wire logic                 tx_valid_o,
	input  wire logic                 tx_ready_i,
	input  wire logic [TAG_WIDTH-1:0] tx_tag_o
);
	// ****************************************************************
	// Helper logic
	// ****************************************************************
	logic [31:0]          exp_len_q;
	logic [31:0]          ro_len_q;
	logic [TAG_WIDTH-1:0] tag_q;
	logic                 abort_w;
	assign abort_w = psel_i && penable_i && pwrite_i
		&& paddr_i == acq_pkg::OFS_CTRL
		&& pwdata_i[acq_pkg::CTRL_ABORT_BIT];
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			exp_len_q <= 32'h0;
			ro_len_q  <= 32'h0;
			tag_q     <= '0;
		end else begin
			exp_len_q <= expose_o ? exp_len_q + 32'h1 : 32'h0;
			ro_len_q  <= readout_o ? ro_len_q + 32'h1 : 32'h0;
			if (tx_valid_o && tx_ready_i) begin
				tag_q <= tx_tag_o;
			end
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);

	a_trig_when_ready: assert property (
		$rose(expose_o) |-> $past(ready_o))
		else $error("exposure began without ready");
	a_ready_only_armed: assert property (
		ready_o |-> active_o && !expose_o && !readout_o)
		else $error("ready outside armed state");
	a_exposure_whole_rows: assert property (
		$fell(expose_o) && active_o |-> exp_len_q != 0
		&& exp_len_q % 32'(acq_pkg::ROW_CYCLES) == 0)
		else $error("exposure not whole rows");
	a_readout_whole_rows: assert property (
		$fell(readout_o) && active_o |-> ro_len_q != 0
		&& ro_len_q % 32'(acq_pkg::ROW_CYCLES) == 0)
		else $error("readout not whole rows");
	a_readout_after_exposure: assert property (
		$rose(readout_o) |-> $past(expose_o))
		else $error("readout without exposure");
	a_push_shows_unit: assert property (
		$fell(readout_o) && active_o |-> tx_valid_o)
		else $error("stored unit not offered");
	a_unit_held: assert property (
		tx_valid_o && !tx_ready_i |=> (tx_valid_o && $stable(tx_tag_o))
		|| $fell(active_o)) else $error("unit dropped before accepted");
	a_tag_in_order: assert property (
		tx_valid_o && tx_ready_i && tx_tag_o != 0
		|-> tx_tag_o == TAG_WIDTH'(tag_q + 1'b1))
		else $error("frame tags out of order");
	a_abort_to_idle: assert property (
		abort_w |=> !active_o && !ready_o && !expose_o)
		else $error("abort did not stop");
endmodule

bind camera_acquisition_sequencer camera_acquisition_sequencer_props #(
	.TAG_WIDTH(TAG_WIDTH)
) props_u (
	.clock_i(clock_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.pwdata_i(pwdata_i), .ready_o(ready_o), .expose_o(expose_o),
	.readout_o(readout_o), .active_o(active_o), .tx_valid_o(tx_valid_o),
	.tx_ready_i(tx_ready_i), .tx_tag_o(tx_tag_o)
);

// ### link_sink.sv
// Host link model: takes frame units and records how many and the last tag.
`timescale 1ns/1ps
module link_sink (
	input  wire logic        clock_i,
	input  wire logic        sys_rst_i,
	input  wire logic        stall_i,
	input  wire logic        slow_i,
	input  wire logic        tx_valid_i,
	input  wire logic [15:0] tx_tag_i,
	output logic             tx_ready_o,
	output logic [7:0]       got_o,
	output logic [15:0]      last_tag_o
);
	logic phase_q;
	// A slow host accepts only every other cycle, like a busy grabber.
	assign tx_ready_o = !stall_i && (!slow_i || phase_q);
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			phase_q    <= 1'b0;
			got_o      <= 8'h00;
			last_tag_o <= 16'h0000;
		end else begin
			phase_q <= !phase_q;
			if (tx_valid_i && tx_ready_o) begin
				got_o      <= got_o + 8'h01;
				last_tag_o <= tx_tag_i;
			end
		end
	end
endmodule

// ### test_camera_acquisition_sequencer.sv
// Self-checking bench for the acquisition sequencer.
`timescale 1ns/1ps
module test_camera_acquisition_sequencer;
	logic        clock_i   = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        psel_i    = 1'b0;
	logic        penable_i = 1'b0;
	logic        pwrite_i  = 1'b0;
	logic [7:0]  paddr_i   = 8'h00;
	logic [31:0] pwdata_i  = 32'h0;
	logic        trigger_i = 1'b0;
	logic        stall     = 1'b0;
	logic        slow      = 1'b1;
	logic [31:0] prdata_o;
	logic        pready_o;
	logic        pslverr_o;
	logic        ready_o;
	logic        expose_o;
	logic        readout_o;
	logic        active_o;
	logic        tx_valid_o;
	logic        tx_ready_i;
	logic [15:0] tx_tag_o;
	logic [7:0]  got;
	logic [15:0] last_tag;
	logic [31:0] exp_len;
	logic [31:0] ro_len;
	logic        exp_was;
	logic        ro_was;
	logic [31:0] q;
	int          err_count = 0;
	int          checks_done = 0;
	int          cycles    = 0;
	int          t;

	camera_acquisition_sequencer #(.STORE_DEPTH(2), .TAG_WIDTH(16)) dut_u (
		.clock_i(clock_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .trigger_i(trigger_i), .ready_o(ready_o),
		.expose_o(expose_o), .readout_o(readout_o), .active_o(active_o),
		.tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
		.tx_tag_o(tx_tag_o));
	link_sink sink_u (
		.clock_i(clock_i), .sys_rst_i(sys_rst_i), .stall_i(stall),
		.slow_i(slow), .tx_valid_i(tx_valid_o), .tx_tag_i(tx_tag_o),
		.tx_ready_o(tx_ready_i), .got_o(got), .last_tag_o(last_tag));

	// ****************************************************************
	// Clock, watchdog and phase length meters
	// ****************************************************************
	always #20 clock_i = ~clock_i;
	always @(posedge clock_i) begin
		cycles <= cycles + 1;
		exp_len <= expose_o ? (exp_was ? exp_len + 1 : 32'h1) : exp_len;
		ro_len <= readout_o ? (ro_was ? ro_len + 1 : 32'h1) : ro_len;
		exp_was <= expose_o;
		ro_was <= readout_o;
		if (cycles == 70000) begin
			err_count = err_count + 1;
			close_out();
		end
	end

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic close_out;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic check(input string n, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	// Request is held until pready is seen high at a rising edge.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic e);
		@(posedge clock_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clock_i);
		penable_i <= 1'b1;
		@(posedge clock_i);
		while (pready_o !== 1'b1) @(posedge clock_i);
		q = prdata_o;
		e = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic e;
		apb(1'b1, a, d, e);
	endtask
	task automatic rd(input string n, input logic [7:0] a,
		input logic [31:0] x, input logic xe);
		logic e;
		apb(1'b0, a, 32'h0, e);
		check(n, x, q);
		check("pslverr", 32'(xe), 32'(e));
	endtask
	task automatic pulse(input logic need_ready);
		@(posedge clock_i);
		while (need_ready && ready_o !== 1'b1) @(posedge clock_i);
		trigger_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		trigger_i <= 1'b0;
	endtask
	task automatic wait_phase(input logic which);
		@(posedge clock_i);
		while ((which ? expose_o : active_o) !== 1'b1) @(posedge clock_i);
		while ((which ? expose_o : active_o) !== 1'b0) @(posedge clock_i);
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	initial begin
		repeat (12) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		rd("cfg", acq_pkg::OFS_CFG, 32'h0, 1'b0);
		rd("count", acq_pkg::OFS_FRAME_COUNT, 32'h1, 1'b0);
		rd("exposure", acq_pkg::OFS_EXPOSURE, 32'hA40, 1'b0);
		rd("roi", acq_pkg::OFS_ROI, 32'h438, 1'b0);
		rd("period", acq_pkg::OFS_PERIOD, 32'h0, 1'b0);
		rd("unmapped", 8'h20, 32'h0, 1'b1);
		// One frame, stray triggers during and after it.
		wr(acq_pkg::OFS_ROI, 32'h1);
		wr(acq_pkg::OFS_EXPOSURE, 32'h1);
		wr(acq_pkg::OFS_CTRL, 32'h1);
		pulse(1'b1);
		while (expose_o !== 1'b1) @(posedge clock_i);
		pulse(1'b0);
		wait_phase(1'b0);
		pulse(1'b0);
		repeat (6) @(posedge clock_i);
		check("exp_len", 32'hA40, exp_len);
		check("ro_len", 32'hA40, ro_len);
		check("got", 32'h1, 32'(got));
		rd("sent", acq_pkg::OFS_SENT, 32'h1, 1'b0);
		// Counted series, internal trigger, link stalled until done.
		// Count equals store depth so memory never overfills.
		stall <= 1'b1;
		slow <= 1'b0;
		wr(acq_pkg::OFS_EXPOSURE, 32'hA41);
		wr(acq_pkg::OFS_FRAME_COUNT, 32'h2);
		wr(acq_pkg::OFS_CFG, 32'h9);
		wr(acq_pkg::OFS_PERIOD, 32'h2400);
		wr(acq_pkg::OFS_CTRL, 32'h1);
		while (expose_o !== 1'b1) @(posedge clock_i);
		t = cycles;
		wait_phase(1'b1);
		while (expose_o !== 1'b1) @(posedge clock_i);
		check("period", 32'h2401, cycles - t);
		wait_phase(1'b0);
		check("exp_len", 32'h1480, exp_len);
		check("held", 32'h1, 32'(tx_valid_o));
		stall <= 1'b0;
		repeat (8) @(posedge clock_i);
		check("got", 32'h3, 32'(got));
		check("tag", 32'h1, 32'(last_tag));
		// Accumulate, global shutter, software trigger.
		wr(acq_pkg::OFS_FRAME_COUNT, 32'h1);
		wr(acq_pkg::OFS_EXPOSURE, 32'h1);
		wr(acq_pkg::OFS_CFG, 32'h6);
		wr(acq_pkg::OFS_CTRL, 32'h1);
		while (ready_o !== 1'b1) @(posedge clock_i);
		wr(acq_pkg::OFS_CTRL, 32'h4);
		wait_phase(1'b0);
		repeat (6) @(posedge clock_i);
		check("ro_len", 32'h1480, ro_len);
		check("got", 32'h4, 32'(got));
		check("tag", 32'h0, 32'(last_tag));
		// Continuous, stalled link: exposure rewrite, then overflow.
		stall <= 1'b1;
		wr(acq_pkg::OFS_ROI, 32'h2);
		wr(acq_pkg::OFS_CFG, 32'hB);
		wr(acq_pkg::OFS_CTRL, 32'h1);
		while (expose_o !== 1'b1) @(posedge clock_i);
		wr(acq_pkg::OFS_EXPOSURE, 32'h1_0000);
		rd("clamped", acq_pkg::OFS_EXPOSURE, 32'h147F, 1'b0);
		while (expose_o !== 1'b0) @(posedge clock_i);
		check("exp_len", 32'hA40, exp_len);
		wait_phase(1'b1);
		check("exp_len", 32'h1480, exp_len);
		wait_phase(1'b0);
		@(posedge clock_i);
		check("flushed", 32'h0, 32'(tx_valid_o));
		rd("status", acq_pkg::OFS_STATUS, 32'h28, 1'b0);
		check("overflow", 32'h1, 32'(q[acq_pkg::ST_OVERFLOW_BIT]));
		stall <= 1'b0;
		// Abort during exposure, then a trigger that must be ignored.
		wr(acq_pkg::OFS_ROI, 32'h1);
		wr(acq_pkg::OFS_EXPOSURE, 32'h1);
		wr(acq_pkg::OFS_CFG, 32'h3);
		wr(acq_pkg::OFS_CTRL, 32'h1);
		pulse(1'b1);
		while (expose_o !== 1'b1) @(posedge clock_i);
		wr(acq_pkg::OFS_CTRL, 32'h2);
		@(posedge clock_i);
		check("active", 32'h0, 32'(active_o));
		pulse(1'b0);
		repeat (3) @(posedge clock_i);
		check("expose", 32'h0, 32'(expose_o));
		rd("sent", acq_pkg::OFS_SENT, 32'h4, 1'b0);
		close_out();
	end
endmodule
